// ### include/modem_status_pkg.sv
/*
 * Shared constants for the modem status input block: APB register offsets,
 * status bit positions, reset values and interrupt event layout.
 * Assumes a 32-bit APB bus with word-aligned registers.
 */
package modem_status_pkg;

    // Register byte offsets
    localparam logic [7:0] OFF_MODEM_STATUS  = 8'h00;
    localparam logic [7:0] OFF_INT_ENABLE    = 8'h04;
    localparam logic [7:0] OFF_EVT_STATUS    = 8'h08;
    localparam logic [7:0] OFF_EVT_ENABLE    = 8'h0C;
    localparam logic [7:0] OFF_EVT_CLEAR     = 8'h10;
    localparam logic [7:0] OFF_TX_CONTROL    = 8'h14;

    // Modem status bit positions
    localparam int unsigned BIT_CTS_CHG  = 0;
    localparam int unsigned BIT_DSR_CHG  = 1;
    localparam int unsigned BIT_RI_CHG   = 2;
    localparam int unsigned BIT_DCD_CHG  = 3;
    localparam int unsigned BIT_CTS      = 4;
    localparam int unsigned BIT_DSR      = 5;
    localparam int unsigned BIT_RI       = 6;
    localparam int unsigned BIT_DCD      = 7;

    // Interrupt enable register: modem status enable bit
    localparam int unsigned BIT_IE_MODEM = 3;

    // Event status layout
    localparam int unsigned EVT_MODEM    = 0;
    localparam int unsigned EVT_WIDTH    = 2;
    localparam int unsigned EVT_TX_DONE  = 1;

    // Reset values
    localparam logic [3:0] RST_LINES_N   = 4'hF;
    localparam logic [7:0] RST_INT_EN    = 8'h00;
    localparam logic [1:0] RST_EVT       = 2'h0;
    localparam logic [7:0] RST_TX_LEN    = 8'h00;

    // Transmit bit period in cycles
    localparam int unsigned TX_BIT_CYCLES = 16;

endpackage

// ### src/line_edge_detect.sv
/*
 * Samples one active-low modem line, presents its true level, and flags
 * rise and any change between successive samples.
 * Assumes the line is synchronous to pclk.
 */
`timescale 1ns/1ps
module line_edge_detect
(
    input  wire logic pclk,        // Clock
    input  wire logic presetn,     // Async reset, active low
    input  wire logic line_n,      // Active-low line
    output logic      level,       // Inverted current level
    output logic      rise,        // Pulse: line went low to high
    output logic      change       // Pulse: line changed
);
    import modem_status_pkg::*;

    logic prev_n_ff;

    // Remember the previous sample; idle high after reset
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prev_n_ff <= 1'b1;
        else
            prev_n_ff <= line_n;
    end

    // Level and edge outputs
    assign level  = ~line_n;
    assign rise   = line_n & ~prev_n_ff;
    assign change = line_n ^ prev_n_ff;
endmodule

// ### src/tx_shifter.sv
/*
 * Minimal serial transmitter: sends a byte 8N1 with a fixed bit period.
 * Assumes start is a one-cycle pulse taken only while idle; no handshake
 * input gates it.
 */
`timescale 1ns/1ps
module tx_shifter
(
    input  wire logic       pclk,     // Clock
    input  wire logic       presetn,  // Async reset, active low
    input  wire logic       start,    // Pulse: send data
    input  wire logic [7:0] data,     // Byte to send
    output logic            busy,     // Frame in progress
    output logic            done,     // Pulse: frame finished
    output logic            txd       // Serial output
);
    import modem_status_pkg::*;

    logic [9:0] shift_ff;
    logic [3:0] bits_ff;
    logic [4:0] tick_ff;
    logic       done_ff;

    // Shift one bit per period, start-data-stop
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            shift_ff <= 10'h3FF;
            bits_ff  <= 4'h0;
            tick_ff  <= 5'h00;
            done_ff  <= 1'b0;
        end
        else
        begin
            done_ff <= 1'b0;
            if (bits_ff == 4'h0)
            begin
                if (start)
                begin
                    shift_ff <= {1'b1, data, 1'b0};
                    bits_ff  <= 4'hA;
                    tick_ff  <= 5'(TX_BIT_CYCLES - 1);
                end
            end
            else if (tick_ff == 5'h00)
            begin
                shift_ff <= {1'b1, shift_ff[9:1]};
                bits_ff  <= bits_ff - 4'h1;
                tick_ff  <= 5'(TX_BIT_CYCLES - 1);
                done_ff  <= (bits_ff == 4'h1);
            end
            else
                tick_ff <= tick_ff - 5'h01;
        end
    end

    assign txd  = shift_ff[0];
    assign busy = (bits_ff != 4'h0);
    assign done = done_ff;
endmodule

// ### src/modem_status_inputs.sv
/*
 * Modem status input logic of one serial port with an APB register slave,
 * sticky event interrupt and a small transmitter for checking independence.
 * Assumes modem lines are synchronous to pclk and an APB master on pclk.
 */
// What this block does
// - Status bit 4 reads the inverse of the clear-to-send line.
// - Status bit 5 reads the inverse of the data-set-ready line.
// - Status bit 6 reads the inverse of the ring-indicator line.
// - Status bit 7 reads the inverse of the carrier-detect line.
// - Clear-to-send rising since last status read sets bit 0.
// - Data-set-ready rising since last status read sets bit 1.
// - Ring-indicator rising since last status read sets bit 2.
// - Carrier-detect rising since last status read sets bit 3.
// - Enable bit 3 set: any handshake line change raises interrupt.
// - Transmitter never waits on or is gated by clear-to-send.
`timescale 1ns/1ps
module modem_status_inputs
(
    input  wire logic        pclk,             // APB clock, 10 MHz
    input  wire logic        presetn,          // Async reset, active low
    input  wire logic        psel,             // APB select
    input  wire logic        penable,          // APB access phase
    input  wire logic        pwrite,           // APB write
    input  wire logic [7:0]  paddr,            // APB byte address
    input  wire logic [31:0] pwdata,           // APB write data
    output logic      [31:0] prdata,           // APB read data
    output logic             pready,           // APB ready
    output logic             pslverr,          // APB error
    input  wire logic        clear_to_send_n,  // Modem line, active low
    input  wire logic        data_set_ready_n, // Modem line, active low
    input  wire logic        carrier_detect_n, // Modem line, active low
    input  wire logic        ring_indicator_n, // Modem line, active low
    output logic             txd,              // Serial transmit data
    output logic             modem_irq,        // Serial port interrupt
    output logic             irq               // Event interrupt
);
    import modem_status_pkg::*;

    logic [3:0] lvl;
    logic [3:0] rise;
    logic [3:0] chg;
    logic [3:0] flags_ff;
    logic [3:0] nxt_flags;
    logic [7:0] int_enable_ff;
    logic       modem_pend_ff;
    logic       nxt_modem_pend;
    logic [1:0] evt_status_ff;
    logic [1:0] evt_enable_ff;
    logic [1:0] nxt_evt_status;
    logic [31:0] prdata_ff;
    logic       tx_start;
    logic       tx_busy;
    logic       tx_done;
    logic [7:0] status_val;
    logic       wr_acc;
    logic       rd_acc;
    logic       msr_read;
    logic       addr_ok;
    logic [3:0] lines_n;

    // Line order: 0 cts, 1 dsr, 2 ri, 3 dcd (matches change bit order)
    assign lines_n = {carrier_detect_n, ring_indicator_n,
                      data_set_ready_n, clear_to_send_n};

    // One edge detector per handshake line
    generate
        for (genvar i = 0; i < 4; i++)
        begin : g_line
            line_edge_detect u_det
            (
                .pclk    (pclk),
                .presetn (presetn),
                .line_n  (lines_n[i]),
                .level   (lvl[i]),
                .rise    (rise[i]),
                .change  (chg[i])
            );
        end
    endgenerate

    // APB access decode; slave answers with no wait states
    assign wr_acc   = psel & penable & pwrite;
    assign rd_acc   = psel & penable & ~pwrite;
    assign addr_ok  = (paddr == OFF_MODEM_STATUS) ||
                      (paddr == OFF_INT_ENABLE)   ||
                      (paddr == OFF_EVT_STATUS)   ||
                      (paddr == OFF_EVT_ENABLE)   ||
                      (paddr == OFF_EVT_CLEAR)    ||
                      (paddr == OFF_TX_CONTROL);
    assign pready   = 1'b1;
    assign pslverr  = psel & penable & ~addr_ok;
    assign msr_read = rd_acc & (paddr == OFF_MODEM_STATUS);

    // Status byte: live inverted levels above, change flags below
    assign status_val = {lvl,
                         flags_ff};

    // Change flags: read clears, a rise in the same cycle still sets
    always_comb
    begin
        nxt_flags = flags_ff;
        if (msr_read)
            nxt_flags = 4'h0;
        nxt_flags = nxt_flags | rise;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            flags_ff <= 4'h0;
        else
            flags_ff <= nxt_flags;
    end

    // Interrupt enable register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            int_enable_ff <= RST_INT_EN;
        else if (wr_acc && paddr == OFF_INT_ENABLE)
            int_enable_ff <= pwdata[7:0];
    end

    // Modem interrupt pending: any change sets, status read clears
    always_comb
    begin
        nxt_modem_pend = modem_pend_ff;
        if (msr_read)
            nxt_modem_pend = 1'b0;
        if (|chg)
            nxt_modem_pend = 1'b1;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            modem_pend_ff <= 1'b0;
        else
            modem_pend_ff <= nxt_modem_pend;
    end

    assign modem_irq = modem_pend_ff & int_enable_ff[BIT_IE_MODEM];

    // Transmitter start: write to tx control while idle
    assign tx_start = wr_acc & (paddr == OFF_TX_CONTROL) & ~tx_busy;

    tx_shifter u_tx
    (
        .pclk    (pclk),
        .presetn (presetn),
        .start   (tx_start),
        .data    (pwdata[7:0]),
        .busy    (tx_busy),
        .done    (tx_done),
        .txd     (txd)
    );

    // Sticky events: set wins over write-one-to-clear
    always_comb
    begin
        nxt_evt_status = evt_status_ff;
        if (wr_acc && paddr == OFF_EVT_CLEAR)
            nxt_evt_status = evt_status_ff & ~pwdata[1:0];
        nxt_evt_status[EVT_MODEM]   = nxt_evt_status[EVT_MODEM] | (|chg);
        nxt_evt_status[EVT_TX_DONE] = nxt_evt_status[EVT_TX_DONE] | tx_done;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            evt_status_ff <= RST_EVT;
        else
            evt_status_ff <= nxt_evt_status;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            evt_enable_ff <= RST_EVT;
        else if (wr_acc && paddr == OFF_EVT_ENABLE)
            evt_enable_ff <= pwdata[1:0];
    end

    assign irq = |(evt_status_ff & evt_enable_ff);

    // Read data mux, registered during setup so it is valid in access
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata_ff <= 32'h0000_0000;
        else if (psel && !penable && !pwrite)
        begin
            unique case (paddr)
                OFF_MODEM_STATUS: prdata_ff <= {24'h000000, status_val};
                OFF_INT_ENABLE:   prdata_ff <= {24'h000000, int_enable_ff};
                OFF_EVT_STATUS:   prdata_ff <= {30'h0, evt_status_ff};
                OFF_EVT_ENABLE:   prdata_ff <= {30'h0, evt_enable_ff};
                OFF_TX_CONTROL:   prdata_ff <= {31'h0, tx_busy};
                default:          prdata_ff <= 32'h0000_0000;
            endcase
        end
    end

    // Flags set between setup and access are merged into the read value
    assign prdata = (paddr == OFF_MODEM_STATUS) ?
                    {prdata_ff[31:8], lvl, prdata_ff[3:0] | flags_ff} :
                    prdata_ff;

    // Assertions
    cts_level_a: assert property (@(posedge pclk) disable iff (!presetn)
        status_val[BIT_CTS] == !clear_to_send_n)
        else $error("cts level wrong");
    dsr_level_a: assert property (@(posedge pclk) disable iff (!presetn)
        status_val[BIT_DSR] == !data_set_ready_n)
        else $error("dsr level wrong");
    ri_level_a: assert property (@(posedge pclk) disable iff (!presetn)
        status_val[BIT_RI] == !ring_indicator_n)
        else $error("ri level wrong");
    dcd_level_a: assert property (@(posedge pclk) disable iff (!presetn)
        status_val[BIT_DCD] == !carrier_detect_n)
        else $error("dcd level wrong");
    cts_rise_a: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(clear_to_send_n) |=> flags_ff[BIT_CTS_CHG])
        else $error("cts rise not flagged");
    dsr_rise_a: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(data_set_ready_n) |=> flags_ff[BIT_DSR_CHG])
        else $error("dsr rise not flagged");
    ri_rise_a: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(ring_indicator_n) |=> flags_ff[BIT_RI_CHG])
        else $error("ri rise not flagged");
    dcd_rise_a: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(carrier_detect_n) |=> flags_ff[BIT_DCD_CHG])
        else $error("dcd rise not flagged");
    modem_irq_a: assert property (@(posedge pclk) disable iff (!presetn)
        (chg != 4'h0) && int_enable_ff[BIT_IE_MODEM] && !wr_acc
        |=> modem_irq)
        else $error("modem irq missing");
    tx_free_a: assert property (@(posedge pclk) disable iff (!presetn)
        wr_acc && paddr == OFF_TX_CONTROL && !tx_busy |=> tx_busy)
        else $error("tx did not start");
    read_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
        msr_read && rise == 4'h0 |=> flags_ff == 4'h0)
        else $error("flags not cleared");
endmodule

// ### test/modem_line_model.sv
/*
 * Modem model: drives the four active-low handshake lines.
 * Assumes bench commands on pclk; slow mode answers two cycles late.
 */
`timescale 1ns/1ps
module modem_line_model
(
    input  wire logic       pclk,    // Clock
    input  wire logic       presetn, // Reset, active low
    input  wire logic [3:0] want_n,  // Wanted levels: dcd ri dsr cts
    input  wire logic       slow,    // Answer late
    output logic      [3:0] line_n   // Lines to the block
);
    logic [3:0] d1_ff;
    logic [3:0] d2_ff;
    // Delay pipe; lines idle inactive high through reset
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            d1_ff  <= 4'hF;
            d2_ff  <= 4'hF;
            line_n <= 4'hF;
        end
        else
        begin
            d1_ff  <= want_n;
            d2_ff  <= d1_ff;
            line_n <= slow ? d2_ff : want_n;
        end
    end
endmodule

// ### test/modem_status_inputs_bench.sv
/*
 * Self-checking bench for the modem status input block.
 * Assumes the modem line model beside it and APB on a 100 ns clock.
 */
`timescale 1ns/1ps
module modem_status_inputs_bench;
    import modem_status_pkg::*;
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [3:0]  want_n;
    logic        slow;
    logic [3:0]  line_n;
    logic        txd;
    logic        modem_irq;
    logic        irq;
    logic [31:0] rd;
    logic        err;
    logic [3:0]  flags;
    logic [3:0]  prev_n;
    logic [7:0]  d;
    int          err_total;
    int          compares;
    int          i;
    int          k;

    // Free-running clock
    initial pclk = 1'b0;
    always #50 pclk = ~pclk;

    modem_status_inputs modem_status_inputs_i (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .clear_to_send_n(line_n[0]),
        .data_set_ready_n(line_n[1]), .ring_indicator_n(line_n[2]),
        .carrier_detect_n(line_n[3]), .txd(txd), .modem_irq(modem_irq),
        .irq(irq));

    modem_line_model modem_line_model_i (.pclk(pclk), .presetn(presetn),
        .want_n(want_n), .slow(slow), .line_n(line_n));

    // Verdict and end of run
    task automatic test_done();
        $display("counts: compares=%0d mismatches=%0d", compares, err_total);
        if (err_total == 0 && compares > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            err_total++;
            $display("ERROR t=%0t word %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        compares++;
        if (got !== exp)
        begin
            err_total++;
            $display("ERROR t=%0t bit %b expected %b", $time, got, exp);
        end
    endtask

    // One APB transfer; holds the request until pready is sampled high
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 50);
        rd       = prdata;
        err      = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    // Command the modem and track rises of each line since the last read
    task automatic set_lines(input logic [3:0] v, input logic s);
        @(posedge pclk);
        want_n <= v;
        slow   <= s;
        flags   = flags | (v & ~prev_n);
        prev_n  = v;
        repeat (6) @(posedge pclk);
    endtask

    task automatic chk_status();
        apb(1'b0, OFF_MODEM_STATUS, 32'h0);
        chk_word({28'h0, rd[7:4]}, {28'h0, ~prev_n});
        chk_word({28'h0, rd[3:0]}, {28'h0, flags});
        chk_word(rd, {24'h0, ~prev_n, flags});
        flags = 4'h0;
    endtask

    // Watchdog against a hang
    initial
    begin
        #(100 * 20000);
        err_total++;
        test_done();
    end

    initial
    begin
        presetn   = 1'b0;
        psel      = 1'b0;
        penable   = 1'b0;
        pwrite    = 1'b0;
        paddr     = 8'h00;
        pwdata    = 32'h0;
        want_n    = 4'hF;
        slow      = 1'b0;
        flags     = 4'h0;
        prev_n    = 4'hF;
        err_total = 0;
        compares  = 0;
        void'($urandom(32'h365f4de9));
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        chk_status();
        apb(1'b0, OFF_INT_ENABLE, 32'h0);
        chk_word(rd, {24'h0, RST_INT_EN});
        $display("test reset done");
        // Each line alone, then random patterns, some with two changes
        for (i = 0; i < 4; i++)
        begin
            set_lines(4'hF ^ (4'h1 << i), 1'b0);
            chk_status();
            set_lines(4'hF, 1'b1);
            chk_status();
        end
        for (i = 0; i < 16; i++)
        begin
            set_lines(4'($urandom), 1'($urandom));
            if (i % 3 == 0)
                set_lines(4'($urandom), 1'b0);
            chk_status();
        end
        chk_status();
        $display("test levels and flags done");
        // Modem interrupt masked, then enabled on rise and on fall
        set_lines(4'hF, 1'b0);
        chk_status();
        set_lines(4'hE, 1'b0);
        chk_bit(modem_irq, 1'b0);
        chk_status();
        apb(1'b1, OFF_INT_ENABLE, 32'h8);
        set_lines(4'hF, 1'b0);
        chk_bit(modem_irq, 1'b1);
        chk_status();
        repeat (2) @(posedge pclk);
        chk_bit(modem_irq, 1'b0);
        set_lines(4'h7, 1'b1);
        chk_bit(modem_irq, 1'b1);
        chk_status();
        // Event interrupt: raise, mask, clear
        apb(1'b1, OFF_EVT_ENABLE, 32'h1);
        apb(1'b0, OFF_EVT_STATUS, 32'h0);
        chk_word(rd, 32'h1);
        chk_bit(irq, 1'b1);
        apb(1'b1, OFF_EVT_ENABLE, 32'h0);
        @(posedge pclk);
        chk_bit(irq, 1'b0);
        apb(1'b1, OFF_EVT_CLEAR, 32'h3);
        apb(1'b1, OFF_EVT_ENABLE, 32'h1);
        @(posedge pclk);
        chk_bit(irq, 1'b0);
        apb(1'b1, 8'h20, 32'hFF);
        chk_bit(err, 1'b1);
        apb(1'b0, 8'h20, 32'h0);
        chk_bit(err, 1'b1);
        chk_word(rd, 32'h0);
        $display("test interrupts done");
        // Frame goes out whatever the clear-to-send level
        for (i = 0; i < 2; i++)
        begin
            set_lines({prev_n[3:1], i[0]}, 1'b0);
            apb(1'b1, OFF_EVT_CLEAR, 32'h3);
            d = 8'($urandom);
            apb(1'b1, OFF_TX_CONTROL, {24'h0, d});
            k = 0;
            while (txd !== 1'b0 && k < 100)
            begin
                @(posedge pclk);
                k++;
            end
            repeat (7) @(posedge pclk);
            chk_bit(txd, 1'b0);
            for (k = 0; k < 8; k++)
            begin
                repeat (TX_BIT_CYCLES) @(posedge pclk);
                chk_bit(txd, d[k]);
            end
            repeat (TX_BIT_CYCLES) @(posedge pclk);
            chk_bit(txd, 1'b1);
            repeat (TX_BIT_CYCLES) @(posedge pclk);
            apb(1'b0, OFF_EVT_STATUS, 32'h0);
            chk_word(rd, 32'h2);
        end
        $display("test transmit done");
        test_done();
    end
endmodule
